// file: verilog/hbp_port.sv
// Purpose: host parallel bus port: decode, wait, straps, irq
// Assumes: pins and bus clock sampled by clk, 20 MHz
// Notes:   local select is the only unregistered output
`timescale 1ns/10ps
module hbp_port #(
    parameter bit IS_BUS32 = 1'b0,           // 32-bit package
    parameter int ROM_WIDTH = 1              // width code from rom
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic [15:1]                 addrPin,
    input  wire logic                        addrQualifierLow,
    input  wire logic                        addrLatchStrobe,
    input  wire logic                        readStrobeLow,
    input  wire logic                        writeStrobeLow,
    input  wire logic                        cycleQualifier,
    input  wire logic                        syncWriteRead,
    input  wire logic                        busClk,
    input  wire logic                        syncBusStrap,
    input  wire logic                        romPresentStrap,
    input  wire logic                        romSerialIn,
    input  wire logic                        coreEvent,
    input  wire logic [hbp_pkg::REG_AW-1:0]  regAddr,
    input  wire logic [31:0]                 regWdata,
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    output logic      [31:0]                 regRdata,
    output logic                             irqOutLow,
    output logic                             irqOe,
    output logic                             localSelectOut,
    output logic                             asyncWaitReady,
    output logic                             asyncWaitOe,
    output logic                             cfgSyncMode,
    output logic                             cfgBurstMode,
    output logic                             cfgRomEnable,
    output logic      [1:0]                  cfgWidth
);
    // ------------------------------------------------
    // state
    // ------------------------------------------------
    typedef struct packed {
        hbp_pkg::hbp_boot_type  boot;
        logic [15:1]            addrS1;   // pin sync stage 1
        logic [15:1]            addrS2;
        logic                   aenS1;
        logic                   aenS2;
        logic [6:0]             ctlS1;    // rd,wr,ads,bclk,cyc,swr,x
        logic [6:0]             ctlS2;
        logic [3:0]             prev;     // rd,wr,ads,bclk
        logic [2:0]             strapS1;  // mode, rom, serial in
        logic [2:0]             strapS2;
        logic                   cfgSync;
        logic                   cfgBurst;
        logic                   cfgRom;
        hbp_pkg::hbp_width_type cfgWidth;
        logic [15:0]            base;
        logic [3:0]             status;
        logic [3:0]             enable;
        logic [15:1]            latAddr;
        logic                   latAen;
        logic                   lastWrite;
        logic [2:0]             waitCnt;
        logic                   readyOe;
        logic                   irq;
        logic [31:0]            rdata;
    } hbp_state_type;

    hbp_state_type s_q;  // registered state
    hbp_state_type s_d;  // next state

    // ------------------------------------------------
    // address match against base, shared by pin and sampled paths
    // ------------------------------------------------
    function automatic logic hbp_match(
        input logic [15:1] a,
        input logic        aenLow,
        input logic [15:0] base
    );
        // qualifier high blocks every match
        hbp_match = !aenLow && (a[15:hbp_pkg::DEC_LSB] == base[15:hbp_pkg::DEC_LSB]);
    endfunction

    // ------------------------------------------------
    // local select: straight from pins, so no sync delay
    // ------------------------------------------------
    always_comb begin
        localSelectOut = !hbp_match(addrPin, addrQualifierLow, s_q.base);
    end

    // sampled views of control pins
    logic rdS;      // read strobe, active low
    logic wrS;      // write strobe, active low
    logic adsS;     // address latch strobe
    logic bclkS;    // host bus clock
    logic cycS;     // cycle qualifier
    logic swrS;     // sync direction
    logic hit;      // sampled address match
    assign rdS   = s_q.ctlS2[6];
    assign wrS   = s_q.ctlS2[5];
    assign adsS  = s_q.ctlS2[4];
    assign bclkS = s_q.ctlS2[3];
    assign cycS  = s_q.ctlS2[2];
    assign swrS  = s_q.ctlS2[1];
    assign hit   = hbp_match(s_q.addrS2, s_q.aenS2, s_q.base);

    // ------------------------------------------------
    // next state
    // ------------------------------------------------
    always_comb begin
        logic       run;
        logic       rdFall;
        logic       wrFall;
        logic       adsRise;
        logic       bclkRise;
        logic [3:0] set;
        logic [3:0] clr;
        run      = 1'b0;
        rdFall   = 1'b0;
        wrFall   = 1'b0;
        adsRise  = 1'b0;
        bclkRise = 1'b0;
        set      = 4'h0;
        clr      = 4'h0;
        s_d      = s_q;
        // two-stage pin synchronisers
        s_d.addrS1  = addrPin;
        s_d.addrS2  = s_q.addrS1;
        s_d.aenS1   = addrQualifierLow;
        s_d.aenS2   = s_q.aenS1;
        s_d.ctlS1   = {readStrobeLow, writeStrobeLow, addrLatchStrobe,
                       busClk, cycleQualifier, syncWriteRead, 1'b0};
        s_d.ctlS2   = s_q.ctlS1;
        s_d.strapS1 = {syncBusStrap, romPresentStrap, romSerialIn};
        s_d.strapS2 = s_q.strapS1;
        s_d.prev    = {rdS, wrS, adsS, bclkS};
        run      = (s_q.boot == hbp_pkg::ST_RUN);
        rdFall   = run && s_q.prev[3] && !rdS;
        wrFall   = run && s_q.prev[2] && !wrS;
        adsRise  = run && !s_q.prev[1] && adsS;
        bclkRise = run && !s_q.prev[0] && bclkS;

        // strap capture: wait until the sync chain holds pin values
        case (s_q.boot)
            hbp_pkg::ST_BOOT: begin
                s_d.boot = hbp_pkg::ST_SETTLE;
            end
            hbp_pkg::ST_SETTLE: begin
                s_d.boot = hbp_pkg::ST_SAMPLE;
            end
            hbp_pkg::ST_SAMPLE: begin
                s_d.boot     = hbp_pkg::ST_RUN;
                s_d.cfgSync  = !s_q.strapS2[2];
                s_d.cfgBurst = s_q.strapS2[2] && IS_BUS32;
                s_d.cfgRom   = s_q.strapS2[1];
                if (IS_BUS32) begin
                    s_d.cfgWidth = hbp_pkg::WIDTH_32;
                end else if (s_q.strapS2[1]) begin
                    s_d.cfgWidth = hbp_pkg::hbp_width_type'(ROM_WIDTH[1:0]);
                end else if (s_q.strapS2[0]) begin
                    s_d.cfgWidth = hbp_pkg::WIDTH_16;
                end else begin
                    s_d.cfgWidth = hbp_pkg::WIDTH_8;
                end
            end
            default: begin
                s_d.boot = hbp_pkg::ST_RUN;  // config frozen until reset
            end
        endcase

        // address latch on strobe rising edge
        if (adsRise) begin
            s_d.latAddr = s_q.addrS2;
            s_d.latAen  = s_q.aenS2;
        end

        // host accesses by mode
        if (s_q.cfgSync) begin
            // command phase seen on a bus clock edge
            if (bclkRise && !cycS && hit) begin
                set[hbp_pkg::EVT_CMD] = 1'b1;
                s_d.lastWrite = swrS;
            end
        end else if (s_q.cfgBurst) begin
            if (bclkRise && hit) begin
                set[hbp_pkg::EVT_CMD] = 1'b1;
                s_d.lastWrite = !cycS;
            end
        end else begin
            // async strobes: extend the cycle by holding ready low
            if (rdFall && hit) begin
                set[hbp_pkg::EVT_RD] = 1'b1;
                s_d.lastWrite = 1'b0;
            end
            if (wrFall && hit) begin
                set[hbp_pkg::EVT_WR] = 1'b1;
                s_d.lastWrite = 1'b1;
            end
        end

        // wait counter runs on clk only, never on the host clock
        if ((set[hbp_pkg::EVT_RD] || set[hbp_pkg::EVT_WR]) && !s_q.readyOe) begin
            s_d.readyOe = 1'b1;
            s_d.waitCnt = 3'(hbp_pkg::WAIT_CYC - 1);
        end else if (s_q.readyOe && (s_q.waitCnt == 3'h0)) begin
            s_d.readyOe = 1'b0;
        end else if (s_q.readyOe) begin
            s_d.waitCnt = s_q.waitCnt - 3'h1;
        end

        set[hbp_pkg::EVT_EXT] = coreEvent;

        // register writes
        if (regWrite) begin
            if (regAddr == hbp_pkg::OFF_BASE) begin
                s_d.base = regWdata[15:0];
            end else if (regAddr == hbp_pkg::OFF_CLEAR) begin
                clr = regWdata[3:0];
            end else if (regAddr == hbp_pkg::OFF_ENA) begin
                s_d.enable = regWdata[3:0];
            end
        end
        // set wins over clear in the same cycle
        s_d.status = (s_q.status & ~clr) | set;
        s_d.irq    = |(s_d.status & s_d.enable);

        // register reads, data valid next cycle only
        s_d.rdata = 32'h0;
        if (regRead) begin
            if (regAddr == hbp_pkg::OFF_BASE) begin
                s_d.rdata = {16'h0, s_q.base};
            end else if (regAddr == hbp_pkg::OFF_STAT) begin
                s_d.rdata = {28'h0, s_q.status};
            end else if (regAddr == hbp_pkg::OFF_ENA) begin
                s_d.rdata = {28'h0, s_q.enable};
            end else if (regAddr == hbp_pkg::OFF_CFG) begin
                s_d.rdata[hbp_pkg::CFG_SYNC]  = s_q.cfgSync;
                s_d.rdata[hbp_pkg::CFG_BURST] = s_q.cfgBurst;
                s_d.rdata[hbp_pkg::CFG_ROM]   = s_q.cfgRom;
                s_d.rdata[hbp_pkg::CFG_WLSB +: 2] = s_q.cfgWidth;
            end else if (regAddr == hbp_pkg::OFF_LATCH) begin
                s_d.rdata[15:1] = s_q.latAddr;
                s_d.rdata[hbp_pkg::LAT_AEN] = s_q.latAen;
                s_d.rdata[hbp_pkg::LAT_DIR] = s_q.lastWrite;
            end
        end
    end

    // ------------------------------------------------
    // state register
    // ------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q          <= '0;
            s_q.base     <= hbp_pkg::BASE_RESET;
            s_q.ctlS1    <= 7'h60;   // strobes idle high, latch strobe and bus clock idle low
            s_q.ctlS2    <= 7'h60;
            s_q.prev     <= 4'hc;    // matches idle pins, so no false edge after reset
            s_q.aenS1    <= 1'b1;
            s_q.aenS2    <= 1'b1;
            s_q.cfgSync  <= 1'b1;
            s_q.cfgWidth <= hbp_pkg::WIDTH_8;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------
    assign regRdata       = s_q.rdata;
    assign irqOutLow      = !s_q.irq;
    assign irqOe          = s_q.irq;        // open drain: drive only low
    assign asyncWaitReady = !s_q.readyOe;
    assign asyncWaitOe    = s_q.readyOe;
    assign cfgSyncMode    = s_q.cfgSync;
    assign cfgBurstMode   = s_q.cfgBurst;
    assign cfgRomEnable   = s_q.cfgRom;
    assign cfgWidth       = s_q.cfgWidth;

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    irq_level_a: assert property (irqOe == |(s_q.status & s_q.enable))
        else $error("irq pin does not follow enabled status");
    irq_hold_a: assert property (irqOe && !(regWrite && regAddr == hbp_pkg::OFF_CLEAR)
        && !$fell(s_q.enable[0]) |=> irqOe || (s_q.enable != $past(s_q.enable)))
        else $error("irq released without a clear");
    select_decode_a: assert property (localSelectOut ==
        !(!addrQualifierLow && addrPin[15:4] == s_q.base[15:4]))
        else $error("local select decode wrong");
    select_qual_a: assert property (addrQualifierLow |-> localSelectOut)
        else $error("select with qualifier high");
    wait_len_a: assert property ($rose(asyncWaitOe) |->
        (asyncWaitOe && !asyncWaitReady)[*4] ##1 !asyncWaitOe)
        else $error("ready extension length wrong");
    strap_mode_a: assert property (s_q.boot == hbp_pkg::ST_SAMPLE |=>
        cfgSyncMode == !$past(s_q.strapS2[2]) && cfgRomEnable == $past(s_q.strapS2[1]))
        else $error("strap mode capture wrong");
    strap_width_a: assert property (s_q.boot == hbp_pkg::ST_SAMPLE
        && !s_q.strapS2[1] && !IS_BUS32 |=> cfgWidth == ($past(s_q.strapS2[0]) ? 2'h1 : 2'h0))
        else $error("width strap capture wrong");
    strap_fixed_a: assert property (s_q.boot == hbp_pkg::ST_RUN |=>
        $stable({cfgSyncMode, cfgBurstMode, cfgRomEnable, cfgWidth}))
        else $error("config changed after sampling");
    addr_latch_a: assert property (s_q.boot == hbp_pkg::ST_RUN && !s_q.prev[1] && adsS |=>
        s_q.latAddr == $past(s_q.addrS2) && s_q.latAen == $past(s_q.aenS2))
        else $error("address not latched on strobe edge");

    async_read_c: cover property ($rose(asyncWaitOe) ##[1:8] $rose(asyncWaitReady));
    sync_cmd_c:   cover property (cfgSyncMode && $rose(s_q.status[hbp_pkg::EVT_CMD]));
    irq_cycle_c:  cover property ($rose(irqOe) ##[1:200] $fell(irqOe));
    sel_c:        cover property ($fell(localSelectOut));
endmodule

// file: verilog/hbp_pkg.sv
// Purpose: constants and types of the host bus port
// Assumes: 20 MHz core clock
// Notes:   register offsets are byte addresses
package hbp_pkg;
    // ------------------------------------------------
    // register map
    // ------------------------------------------------
    localparam int          REG_AW    = 8;
    localparam logic [7:0]  OFF_BASE  = 8'h00; // base address
    localparam logic [7:0]  OFF_STAT  = 8'h04; // sticky status, ro
    localparam logic [7:0]  OFF_CLEAR = 8'h08; // status clear, wo
    localparam logic [7:0]  OFF_ENA   = 8'h0c; // irq enable
    localparam logic [7:0]  OFF_CFG   = 8'h10; // strap result, ro
    localparam logic [7:0]  OFF_LATCH = 8'h14; // latched address, ro
    localparam logic [15:0] BASE_RESET = 16'h0300;
    localparam int          DEC_LSB   = 4;      // low decoded bit
    // ------------------------------------------------
    // status bits
    // ------------------------------------------------
    localparam int EVT_W   = 4;
    localparam int EVT_RD  = 0; // async read hit
    localparam int EVT_WR  = 1; // async write hit
    localparam int EVT_CMD = 2; // sync or burst command hit
    localparam int EVT_EXT = 3; // core event
    // ------------------------------------------------
    // config and latch fields
    // ------------------------------------------------
    localparam int CFG_SYNC  = 0;
    localparam int CFG_BURST = 1;
    localparam int CFG_ROM   = 2;
    localparam int CFG_WLSB  = 3;
    localparam int LAT_AEN   = 0;
    localparam int LAT_DIR   = 16;
    // ------------------------------------------------
    // timing
    // ------------------------------------------------
    localparam int CLK_NS  = 50;
    localparam int WAIT_NS = 200;  // least cycle extension
    localparam int WAIT_CYC = (WAIT_NS + CLK_NS - 1) / CLK_NS;
    // ------------------------------------------------
    // types
    // ------------------------------------------------
    typedef enum logic [1:0] {
        WIDTH_8  = 2'h0,
        WIDTH_16 = 2'h1,
        WIDTH_32 = 2'h2
    } hbp_width_type;
    typedef enum logic [1:0] {
        ST_BOOT   = 2'h0,
        ST_SETTLE = 2'h1,
        ST_SAMPLE = 2'h3,
        ST_RUN    = 2'h2
    } hbp_boot_type;
endpackage

// file: sim/hbp_host_model.sv
// Purpose: host bus master model for the port pins
// Assumes: clk 50 ns; bus clock 400 ns, only within sync cycles
// Notes:   released address lines show the inverse of the last value
`timescale 1ns/10ps
module hbp_host_model (
    input  wire logic        clk,
    input  wire logic        readyWire,
    output logic      [15:1] addrPin,
    output logic             addrQualifierLow,
    output logic             addrLatchStrobe,
    output logic             readStrobeLow,
    output logic             writeStrobeLow,
    output logic             cycleQualifier,
    output logic             syncWriteRead,
    output logic             busClk
);
    // ------------------------------------------------
    // idle levels: strobes high, bus clock still
    // ------------------------------------------------
    initial begin
        addrPin = 15'h0000;
        addrQualifierLow = 1'b1;
        addrLatchStrobe = 1'b0;
        readStrobeLow = 1'b1;
        writeStrobeLow = 1'b1;
        cycleQualifier = 1'b1;
        syncWriteRead = 1'b0;
        busClk = 1'b0;
    end
    // ------------------------------------------------
    // bus cycles, each entered just after a clk edge
    // ------------------------------------------------
    // end a cycle; stale address would hide a missed sample
    task automatic endAccess();
        readStrobeLow <= 1'b1;
        writeStrobeLow <= 1'b1;
        addrQualifierLow <= 1'b1;
        addrPin <= ~addrPin;
        repeat (4) @(posedge clk);
    endtask
    // address with its qualifier, no strobe
    task automatic setAddr(input logic [15:1] a, input logic q);
        @(posedge clk);
        addrPin <= a;
        addrQualifierLow <= q;
    endtask
    // async access; waitCyc counts clk edges with ready low
    task automatic asyncAccess(input logic [15:1] a, input bit wr, output int waitCyc);
        waitCyc = 0;
        setAddr(a, 1'b0);
        readStrobeLow <= wr;
        writeStrobeLow <= !wr;
        // hold the strobe until ready returns, bounded for a miss
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            if (readyWire === 1'b0) waitCyc++;
            else if (waitCyc > 0) break;
        end
        endAccess();
    endtask
    // sync access: address phase edge, then command phase edge
    task automatic syncAccess(input logic [15:1] a, input bit wr, input bit cq);
        setAddr(a, 1'b0);
        syncWriteRead <= wr;
        cycleQualifier <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            #73 busClk = 1'b1;
            #200 busClk = 1'b0;
            cycleQualifier = (k == 0) ? cq : 1'b1;
            #127;
        end
        @(posedge clk);
        endAccess();
    endtask
    // address latch strobe rising edge
    task automatic latchAddr(input logic [15:1] a, input logic q);
        setAddr(a, q);
        repeat (3) @(posedge clk);
        addrLatchStrobe <= 1'b1;
        repeat (4) @(posedge clk);
        addrLatchStrobe <= 1'b0;
        endAccess();
    endtask
endmodule

// file: sim/tb_top.sv
// Purpose: self-checking bench of the host bus port
// Assumes: clk 20 MHz, straps set while reset is low
// Notes:   open-drain pins resolved here with pull-ups
`timescale 1ns/10ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin badCount++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    logic        clk = 1'b0, resetn = 1'b0, coreEvent = 1'b0;
    logic        syncBusStrap = 1'b0, romPresentStrap = 1'b0, romSerialIn = 1'b0;
    logic [hbp_pkg::REG_AW-1:0] regAddr = '0;
    logic [31:0] regWdata = '0, regRdata;
    logic        regWrite = 1'b0, regRead = 1'b0;
    logic        irqOutLow, irqOe, localSelectOut, asyncWaitReady, asyncWaitOe;
    logic        cfgSyncMode, cfgBurstMode, cfgRomEnable;
    logic [1:0]  cfgWidth;
    logic [15:1] addrPin;
    logic        addrQualifierLow, addrLatchStrobe, readStrobeLow, writeStrobeLow;
    logic        cycleQualifier, syncWriteRead, busClk;
    logic        irqWire, readyWire; // pin levels with pull-up
    int          badCount = 0, nCompared = 0;
    // ------------------------------------------------
    // clock, pins, instances
    // ------------------------------------------------
    always #25 clk = ~clk;
    assign irqWire = irqOe ? irqOutLow : 1'b1;
    assign readyWire = asyncWaitOe ? asyncWaitReady : 1'b1;
    hbp_port #(.IS_BUS32(1'b0), .ROM_WIDTH(1)) hbp_port_i (
        .clk, .resetn, .addrPin, .addrQualifierLow, .addrLatchStrobe, .readStrobeLow,
        .writeStrobeLow, .cycleQualifier, .syncWriteRead, .busClk, .syncBusStrap,
        .romPresentStrap, .romSerialIn, .coreEvent, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata, .irqOutLow, .irqOe, .localSelectOut, .asyncWaitReady,
        .asyncWaitOe, .cfgSyncMode, .cfgBurstMode, .cfgRomEnable, .cfgWidth);
    hbp_host_model hbp_host_model_i (
        .clk, .readyWire, .addrPin, .addrQualifierLow, .addrLatchStrobe, .readStrobeLow,
        .writeStrobeLow, .cycleQualifier, .syncWriteRead, .busClk);
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic regRd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    // straps stay put from release, as the port samples them then
    task automatic doReset(input logic s, input logic r, input logic e);
        @(posedge clk);
        resetn <= 1'b0;
        syncBusStrap <= s;
        romPresentStrap <= r;
        romSerialIn <= e;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
    task automatic finalReport();
        $display("compared %0d, mismatched %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic tReset();
        logic [31:0] d;
        doReset(1'b0, 1'b0, 1'b0);
        regRd(hbp_pkg::OFF_CFG, d);
        `CHK(d, 32'h0000_0001)
        regRd(hbp_pkg::OFF_BASE, d);
        `CHK(d[15:0], hbp_pkg::BASE_RESET)
        regWr(hbp_pkg::OFF_STAT, 32'h0000_000f);
        regRd(hbp_pkg::OFF_STAT, d);
        `CHK(d, 32'h0000_0000)
        regRd(8'h1c, d);
        `CHK(d, 32'h0000_0000)
        `CHK(irqWire, 1'b1)
        $display("test reset done");
    endtask
    // select must follow the pins in the same cycle
    task automatic tSelect();
        logic [15:0] aTab [4] = '{16'h0300, 16'h030e, 16'h0310, 16'h0300};
        logic        qTab [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
        logic        eTab [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 4; i++) begin
            hbp_host_model_i.setAddr(aTab[i][15:1], qTab[i]);
            #1 `CHK(localSelectOut, eTab[i])
        end
        regWr(hbp_pkg::OFF_BASE, 32'h0000_1230);
        hbp_host_model_i.setAddr(15'h0918, 1'b0);
        #1 `CHK(localSelectOut, 1'b0)
        regWr(hbp_pkg::OFF_BASE, 32'h0000_0300);
        hbp_host_model_i.setAddr(15'h7fff, 1'b1);
        $display("test select done");
    endtask
    task automatic tAsync();
        logic [31:0] d;
        int n;
        doReset(1'b1, 1'b0, 1'b1);
        regRd(hbp_pkg::OFF_CFG, d);
        `CHK(d, 32'h0000_0008)
        `CHK({cfgSyncMode, cfgBurstMode, cfgWidth}, 4'h1)
        hbp_host_model_i.asyncAccess(15'h0180, 1'b0, n);
        `CHK(n, hbp_pkg::WAIT_CYC)
        hbp_host_model_i.asyncAccess(15'h0181, 1'b1, n);
        `CHK(n, hbp_pkg::WAIT_CYC)
        hbp_host_model_i.asyncAccess(15'h0200, 1'b0, n);
        `CHK(n, 0)
        regRd(hbp_pkg::OFF_STAT, d);
        `CHK(d, 32'h0000_0003)
        $display("test async done");
    endtask
    // status holds 0x3 from the async test
    task automatic tIrq();
        logic [31:0] d;
        regWr(hbp_pkg::OFF_ENA, 32'h0000_0008);
        regRd(hbp_pkg::OFF_ENA, d);
        `CHK(d, 32'h0000_0008)
        `CHK(irqWire, 1'b1)
        @(posedge clk) coreEvent <= 1'b1;
        @(posedge clk) coreEvent <= 1'b0;
        #1 `CHK(irqWire, 1'b0)
        regWr(hbp_pkg::OFF_ENA, 32'h0000_0009);
        regWr(hbp_pkg::OFF_CLEAR, 32'h0000_0008);
        regRd(hbp_pkg::OFF_STAT, d);
        `CHK(d, 32'h0000_0003)
        `CHK(irqWire, 1'b0)
        regWr(hbp_pkg::OFF_CLEAR, 32'h0000_0001);
        regRd(hbp_pkg::OFF_CLEAR, d);
        `CHK(d, 32'h0000_0000)
        `CHK(irqWire, 1'b1)
        $display("test irq done");
    endtask
    task automatic tSync();
        logic [31:0] d;
        int n;
        doReset(1'b0, 1'b0, 1'b0);
        hbp_host_model_i.syncAccess(15'h0180, 1'b1, 1'b1);
        hbp_host_model_i.asyncAccess(15'h0180, 1'b0, n);
        `CHK(n, 0)
        regRd(hbp_pkg::OFF_STAT, d);
        `CHK(d, 32'h0000_0000)
        hbp_host_model_i.syncAccess(15'h0180, 1'b1, 1'b0);
        regRd(hbp_pkg::OFF_STAT, d);
        `CHK(d, 32'h0000_0004)
        regRd(hbp_pkg::OFF_LATCH, d);
        `CHK(d[16], 1'b1)
        hbp_host_model_i.syncAccess(15'h0180, 1'b0, 1'b0);
        regRd(hbp_pkg::OFF_LATCH, d);
        `CHK(d[16], 1'b0)
        hbp_host_model_i.latchAddr(15'h022b, 1'b0);
        regRd(hbp_pkg::OFF_LATCH, d);
        `CHK(d[15:0], 16'h0456)
        hbp_host_model_i.latchAddr(15'h0558, 1'b1);
        regRd(hbp_pkg::OFF_LATCH, d);
        `CHK(d[15:0], 16'h0ab1)
        $display("test sync done");
    endtask
    // rom present: width code 1 comes from ROM_WIDTH
    task automatic tStraps();
        logic [31:0] d;
        doReset(1'b1, 1'b1, 1'b0);
        regRd(hbp_pkg::OFF_CFG, d);
        `CHK(d, 32'h0000_000c)
        @(posedge clk);
        syncBusStrap <= 1'b0;
        romPresentStrap <= 1'b0;
        romSerialIn <= 1'b1;
        repeat (8) @(posedge clk);
        regRd(hbp_pkg::OFF_CFG, d);
        `CHK(d, 32'h0000_000c)
        `CHK(cfgRomEnable, 1'b1)
        doReset(1'b1, 1'b0, 1'b0);
        regRd(hbp_pkg::OFF_CFG, d);
        `CHK(d, 32'h0000_0000)
        $display("test straps done");
    endtask
    // ------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------
    initial begin
        tReset();
        tSelect();
        tAsync();
        tIrq();
        tSync();
        tStraps();
        finalReport();
    end
    initial begin
        #2000000;
        badCount++;
        finalReport();
    end
endmodule
